// *** rtl/xb_pkg.sv ***
// Constants and carrier types of the port zero and crossbar block
package xb_pkg;
  localparam logic [7:0] ADDR_LATCH = 8'h80;
  localparam logic [7:0] ADDR_MDOUT = 8'ha4;
  localparam logic [7:0] ADDR_SKIP = 8'hd4;
  localparam logic [7:0] ADDR_XSEL1 = 8'he1;
  localparam logic [7:0] ADDR_XSEL2 = 8'he2;
  localparam logic [7:0] ADDR_INKIND = 8'hf1;
  localparam logic [7:0] ADDR_CMPVAL = 8'hf3;
  localparam logic [7:0] ADDR_CMPMASK = 8'hf4;
  localparam logic [7:0] RST_LATCH = 8'hff;
  localparam logic [7:0] RST_MDOUT = 8'h00;
  localparam logic [7:0] RST_SKIP = 8'h00;
  localparam logic [7:0] RST_XSEL1 = 8'h00;
  localparam logic [7:0] RST_XSEL2 = 8'h00;
  localparam logic [7:0] RST_INKIND = 8'hff;
  localparam logic [7:0] RST_CMPVAL = 8'hff;
  localparam logic [7:0] RST_CMPMASK = 8'h00;
  // First select register fields
  localparam int X1_CMP1_ASYNC = 7;
  localparam int X1_CMP1 = 6;
  localparam int X1_CMP0_ASYNC = 5;
  localparam int X1_CMP0 = 4;
  localparam int X1_SYSCLK = 3;
  localparam int X1_TWO_WIRE = 2;
  localparam int X1_SPI = 1;
  localparam int X1_UART = 0;
  // Second select register fields
  localparam int X2_WEAK_PUD = 7;
  localparam int X2_XBAR_EN = 6;
  localparam int X2_T1 = 5;
  localparam int X2_T0 = 4;
  localparam int X2_ECI = 3;
  localparam int X2_CEX_LSB = 0;
  localparam int CEX_COUNT = 6;
  localparam logic [2:0] CEX_RESERVED = 3'h7;
  // Fixed UART pins per package
  localparam logic [2:0] TX_PIN_LARGE = 3'h1;
  localparam logic [2:0] RX_PIN_LARGE = 3'h2;
  localparam logic [2:0] TX_PIN_SMALL = 3'h4;
  localparam logic [2:0] RX_PIN_SMALL = 3'h5;
  // Crossbar signals in priority order
  localparam int SIG_SDA = 0;
  localparam int SIG_SCL = 1;
  localparam int SIG_SCK = 2;
  localparam int SIG_MISO = 3;
  localparam int SIG_MOSI = 4;
  localparam int SIG_NSS = 5;
  localparam int SIG_CP0 = 6;
  localparam int SIG_CP0A = 7;
  localparam int SIG_CP1 = 8;
  localparam int SIG_CP1A = 9;
  localparam int SIG_SYSCLK = 10;
  localparam int SIG_COUNTER_ARRAY_MODULE_SIGNAL = 11;
  localparam int SIG_ECI = 17;
  localparam int SIG_T0 = 18;
  localparam int SIG_T1 = 19;
  localparam int SIG_COUNT = 20;
  // Signals that only receive from the pin
  localparam logic [19:0] SIG_IS_INPUT = 20'he0008;
  // Signals forced to open drain
  localparam logic [19:0] SIG_IS_OD = 20'h00003;
  localparam logic [2:0] SYNC_STAGES = 3'h3;

  typedef struct packed {
    logic twoWireData;
    logic twoWireClk;
    logic spiClk;
    logic spiMosi;
    logic spiSelect;
    logic cmp0;
    logic cmp0Async;
    logic cmp1;
    logic cmp1Async;
    logic [5:0] cex;
    logic uartTx;
  } xb_periph_out_t;

  typedef struct packed {
    logic twoWireData;
    logic twoWireClk;
    logic spiMiso;
    logic counter_array_external_count;
    logic t0;
    logic t1;
    logic uartRx;
  } xb_periph_in_t;
endpackage

// *** rtl/xb_port_zero.sv ***
// Port zero general-purpose I/O with priority crossbar and pin match
// Function
// [R1] First select bits 7..4 route comparator outputs to pins.
// [R2] First select bit 3 routes divided system clock to a pin.
// [R3] First select bit 2 routes both two-wire bus lines.
// [R4] First select bit 1 routes SPI, three or four pins by mode.
// [R5] First select bit 0 puts UART on fixed package pins.
// [R6] Weak pullups on unless disable bit set; never on analog pins.
// [R7] Second select bit 6 enables the crossbar globally.
// [R8] Second select bits 5..3 route timer and count inputs.
// [R9] Module count field routes modules 0..n-1; 7 reserved.
// [R10] Data writes are latched and drive GPIO pins.
// [R11] Normal data reads return live pin levels.
// [R12] Analog pins read as zero.
// [R13] Read-modify-write reads the latch, not the pins.
// [R14] Open-drain with latch one floats; zero drives low.
// [R15] Analog pin: no pullup, driver or receiver; resets digital.
// [R16] Output mode one push-pull, zero open drain; ignored on analog.
// [R17] Two-wire lines always open drain.
// [R18] Skipped pins are never assigned by the crossbar.
// [R19] Match event when masked pins differ from masked value.
// [R20] Mask zero excludes a pin from matching.
// [R21] Match event requests interrupt when enabled and wakes oscillator.
// [R22] Each signal takes lowest free unskipped pin; UART fixed.
// [R23] Crossbar off keeps all pins as inputs, drivers off.
// [R24] Pullup off on open-drain pin driving zero.
// [R25] Assignment recomputed combinationally, effective next cycle.
// [R26] Pin levels synchronised before reads and matching.
`timescale 1ns/1ps
`default_nettype none
module xb_port_zero #(
  parameter int PIN_COUNT = 8,
  parameter bit LARGE_PACKAGE = 1'b1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  input wire logic sfrRmw,
  output logic [7:0] sfrRdData,
  input wire logic [1:0] clockOutDivider,
  input wire logic spiFourWire,
  input wire logic matchInterruptEnable,
  input wire xb_pkg::xb_periph_out_t periphOut,
  output xb_pkg::xb_periph_in_t periphIn,
  input wire logic [7:0] padIn,
  output logic [7:0] padOut,
  output logic [7:0] padOe,
  output logic [7:0] padPullup,
  output logic matchEvent,
  output logic matchIrq,
  output logic wakeReq
);
  localparam int NS = xb_pkg::SIG_COUNT;

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  if (PIN_COUNT != 8) begin : g_bad_width
    $error("xb_port_zero serves an 8-pin port only");
  end

  logic [7:0] latch_r, mdOut_r, skip_r, xSel1_r, xSel2_r, inKind_r, cmpVal_r, cmpMask_r;
  logic [7:0] padS1_r, padS2_r, padS3_r, padLevel_r, rdData_r;
  logic [7:0] padOut_r, padOe_r, padPull_r;
  logic [2:0] divCnt_r;
  logic clkOut_r, matchEvt_r, matchIrq_r, wake_r;
  xb_pkg::xb_periph_in_t periphIn_r;

  // Register decode
  wire wrLatch = sfrWrEn && sfrAddr == xb_pkg::ADDR_LATCH;
  wire wrMdOut = sfrWrEn && sfrAddr == xb_pkg::ADDR_MDOUT;
  wire wrSkip = sfrWrEn && sfrAddr == xb_pkg::ADDR_SKIP;
  wire wrXSel1 = sfrWrEn && sfrAddr == xb_pkg::ADDR_XSEL1;
  wire wrXSel2 = sfrWrEn && sfrAddr == xb_pkg::ADDR_XSEL2;
  wire wrInKind = sfrWrEn && sfrAddr == xb_pkg::ADDR_INKIND;
  wire wrCmpVal = sfrWrEn && sfrAddr == xb_pkg::ADDR_CMPVAL;
  wire wrCmpMask = sfrWrEn && sfrAddr == xb_pkg::ADDR_CMPMASK;
  wire [7:0] pinRead = padLevel_r & inKind_r; // [R11] [R12] [R15]
  wire [7:0] latchRead = sfrRmw ? latch_r : pinRead; // [R13]
  wire [7:0] rdNxt =
    (sfrAddr == xb_pkg::ADDR_LATCH) ? latchRead :
    (sfrAddr == xb_pkg::ADDR_MDOUT) ? mdOut_r :
    (sfrAddr == xb_pkg::ADDR_SKIP) ? skip_r :
    (sfrAddr == xb_pkg::ADDR_XSEL1) ? xSel1_r :
    (sfrAddr == xb_pkg::ADDR_XSEL2) ? xSel2_r :
    (sfrAddr == xb_pkg::ADDR_INKIND) ? inKind_r :
    (sfrAddr == xb_pkg::ADDR_CMPVAL) ? cmpVal_r :
    (sfrAddr == xb_pkg::ADDR_CMPMASK) ? cmpMask_r : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      latch_r <= xb_pkg::RST_LATCH;
      mdOut_r <= xb_pkg::RST_MDOUT;
      skip_r <= xb_pkg::RST_SKIP;
      xSel1_r <= xb_pkg::RST_XSEL1;
      xSel2_r <= xb_pkg::RST_XSEL2;
      inKind_r <= xb_pkg::RST_INKIND; // [R15]
      cmpVal_r <= xb_pkg::RST_CMPVAL;
      cmpMask_r <= xb_pkg::RST_CMPMASK;
      rdData_r <= 8'h00;
    end else begin
      if (wrLatch) latch_r <= sfrWrData; // [R10]
      if (wrMdOut) mdOut_r <= sfrWrData;
      if (wrSkip) skip_r <= sfrWrData;
      if (wrXSel1) xSel1_r <= sfrWrData;
      if (wrXSel2) xSel2_r <= sfrWrData;
      if (wrInKind) inKind_r <= sfrWrData;
      if (wrCmpVal) cmpVal_r <= sfrWrData;
      if (wrCmpMask) cmpMask_r <= sfrWrData;
      if (sfrRdEn) rdData_r <= rdNxt;
    end
  end

  // Three-stage pin synchroniser; level taken once stages two and three agree
  wire [7:0] syncAgree = ~(padS2_r ^ padS3_r);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      padS1_r <= 8'hff;
      padS2_r <= 8'hff;
      padS3_r <= 8'hff;
      padLevel_r <= 8'hff;
    end else begin
      padS1_r <= padIn;
      padS2_r <= padS1_r;
      padS3_r <= padS2_r;
      padLevel_r <= (padS2_r & syncAgree) | (padLevel_r & ~syncAgree); // [R26]
    end
  end

  // Divided system clock for the pin
  wire [2:0] divLast = 3'((4'h1 << clockOutDivider) - 4'h1);
  wire divTick = divCnt_r >= divLast;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      divCnt_r <= 3'h0;
      clkOut_r <= 1'b0;
    end else begin
      divCnt_r <= divTick ? 3'h0 : divCnt_r + 3'h1; // [R2]
      if (divTick) clkOut_r <= ~clkOut_r;
    end
  end

  // Signal enables, all gated by the global enable
  wire xbarOn = xSel2_r[xb_pkg::X2_XBAR_EN]; // [R7] [R23]
  wire weakOff = xSel2_r[xb_pkg::X2_WEAK_PUD];
  wire [2:0] cexCount = xSel2_r[xb_pkg::X2_CEX_LSB +: 3];
  wire uartOn = xbarOn && xSel1_r[xb_pkg::X1_UART]; // [R5]
  wire [2:0] txPin = LARGE_PACKAGE ? xb_pkg::TX_PIN_LARGE : xb_pkg::TX_PIN_SMALL;
  wire [2:0] rxPin = LARGE_PACKAGE ? xb_pkg::RX_PIN_LARGE : xb_pkg::RX_PIN_SMALL;
  wire [7:0] uartMask = uartOn ? ((8'h01 << txPin) | (8'h01 << rxPin)) : 8'h00;
  wire [5:0] cexEn;
  wire [NS-1:0] sigEn;
  wire [NS-1:0] sigVal;
  for (genvar c = 0; c < xb_pkg::CEX_COUNT; c++) begin : g_cex
    assign cexEn[c] = cexCount != xb_pkg::CEX_RESERVED && cexCount > 3'(c); // [R9]
  end
  assign sigEn = {NS{xbarOn}} & {
    xSel2_r[xb_pkg::X2_T1], xSel2_r[xb_pkg::X2_T0], xSel2_r[xb_pkg::X2_ECI], // [R8]
    cexEn,
    xSel1_r[xb_pkg::X1_SYSCLK], // [R2]
    xSel1_r[xb_pkg::X1_CMP1_ASYNC], xSel1_r[xb_pkg::X1_CMP1], // [R1]
    xSel1_r[xb_pkg::X1_CMP0_ASYNC], xSel1_r[xb_pkg::X1_CMP0],
    xSel1_r[xb_pkg::X1_SPI] && spiFourWire, {3{xSel1_r[xb_pkg::X1_SPI]}}, // [R4]
    {2{xSel1_r[xb_pkg::X1_TWO_WIRE]}} // [R3]
  };
  assign sigVal = {
    3'h7, periphOut.cex, clkOut_r,
    periphOut.cmp1Async, periphOut.cmp1, periphOut.cmp0Async, periphOut.cmp0,
    periphOut.spiSelect, periphOut.spiMosi, 1'b1, periphOut.spiClk,
    periphOut.twoWireClk, periphOut.twoWireData
  };

  // Priority assignment of signals to pins
  logic [7:0] pinTaken, pinPeriph;
  logic [4:0] pinSig [8];
  logic [2:0] sigPin [NS];
  logic [NS-1:0] sigOn;
  logic found;
  always_comb begin
    pinTaken = skip_r | uartMask; // [R18] [R22]
    pinPeriph = 8'h00;
    sigOn = '0;
    found = 1'b0;
    for (int p = 0; p < 8; p++) pinSig[p] = 5'h00;
    for (int s = 0; s < NS; s++) begin
      sigPin[s] = 3'h0;
      found = 1'b0;
      for (int p = 0; p < 8; p++) begin
        if (sigEn[s] && !found && !pinTaken[p]) begin // [R22] [R25]
          found = 1'b1;
          pinTaken[p] = 1'b1;
          pinPeriph[p] = 1'b1;
          pinSig[p] = 5'(s);
          sigPin[s] = 3'(p);
        end
      end
      sigOn[s] = found;
    end
  end

  // Per-pin driver, mode and pullup
  logic [7:0] oeNxt, outNxt, pullNxt;
  for (genvar p = 0; p < 8; p++) begin : g_pin
    wire isTx = uartOn && txPin == 3'(p);
    wire isRx = uartOn && rxPin == 3'(p);
    wire perIn = pinPeriph[p] && xb_pkg::SIG_IS_INPUT[pinSig[p]];
    wire perOd = pinPeriph[p] && xb_pkg::SIG_IS_OD[pinSig[p]];
    wire val = isTx ? periphOut.uartTx : pinPeriph[p] ? sigVal[pinSig[p]] : latch_r[p]; // [R10]
    wire drv = xbarOn && inKind_r[p] && !perIn && !isRx; // [R15] [R16] [R23]
    wire od = !mdOut_r[p] || perOd; // [R16] [R17]
    assign oeNxt[p] = drv && (!od || !val); // [R14]
    assign outNxt[p] = drv && !od && val;
    assign pullNxt[p] = inKind_r[p] && !weakOff && !(oeNxt[p] && !outNxt[p]); // [R6] [R24]
  end

  function automatic logic inFrom(input logic on, input logic [2:0] pin, input logic [7:0] lvl);
    inFrom = on ? lvl[pin] : 1'b1;
  endfunction

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      padOut_r <= 8'h00;
      padOe_r <= 8'h00;
      padPull_r <= 8'h00;
      periphIn_r <= '1;
    end else begin
      padOut_r <= outNxt;
      padOe_r <= oeNxt;
      padPull_r <= pullNxt;
      periphIn_r.twoWireData <= inFrom(sigOn[xb_pkg::SIG_SDA], sigPin[xb_pkg::SIG_SDA], pinRead);
      periphIn_r.twoWireClk <= inFrom(sigOn[xb_pkg::SIG_SCL], sigPin[xb_pkg::SIG_SCL], pinRead);
      periphIn_r.spiMiso <= inFrom(sigOn[xb_pkg::SIG_MISO], sigPin[xb_pkg::SIG_MISO], pinRead);
      periphIn_r.counter_array_external_count <= inFrom(sigOn[xb_pkg::SIG_ECI], sigPin[xb_pkg::SIG_ECI], pinRead); // [R8]
      periphIn_r.t0 <= inFrom(sigOn[xb_pkg::SIG_T0], sigPin[xb_pkg::SIG_T0], pinRead);
      periphIn_r.t1 <= inFrom(sigOn[xb_pkg::SIG_T1], sigPin[xb_pkg::SIG_T1], pinRead);
      periphIn_r.uartRx <= inFrom(uartOn, rxPin, pinRead); // [R5]
    end
  end

  // Port match compare on the synchronised levels
  wire matchDiff = (pinRead & cmpMask_r) != (cmpVal_r & cmpMask_r); // [R19] [R20]
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      matchEvt_r <= 1'b0;
      matchIrq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      matchEvt_r <= matchDiff; // [R19]
      matchIrq_r <= matchDiff && matchInterruptEnable; // [R21]
      wake_r <= matchDiff; // [R21]
    end
  end

  assign sfrRdData = rdData_r;
  assign padOut = padOut_r;
  assign padOe = padOe_r;
  assign padPullup = padPull_r;
  assign periphIn = periphIn_r;
  assign matchEvent = matchEvt_r;
  assign matchIrq = matchIrq_r;
  assign wakeReq = wake_r;

  logic [2:0] sdaPinQ;
  logic sdaOnQ;
  always_ff @(posedge ref_clk) begin
    sdaPinQ <= sigPin[xb_pkg::SIG_SDA];
    sdaOnQ <= sigOn[xb_pkg::SIG_SDA] && !srst;
  end

  chk_latch_write: assert property (@(posedge ref_clk) disable iff (srst) // [R10]
    wrLatch |=> latch_r == $past(sfrWrData)) else $error("latch not loaded");
  chk_read_analog: assert property (@(posedge ref_clk) disable iff (srst) // [R12]
    sfrRdEn && sfrAddr == xb_pkg::ADDR_LATCH && !sfrRmw |=> (sfrRdData & ~$past(inKind_r)) == 8'h00)
    else $error("analog pin read nonzero");
  chk_read_pins: assert property (@(posedge ref_clk) disable iff (srst) // [R11]
    sfrRdEn && sfrAddr == xb_pkg::ADDR_LATCH && !sfrRmw |=> sfrRdData == $past(padLevel_r & inKind_r))
    else $error("pin read mismatch");
  chk_rmw_latch: assert property (@(posedge ref_clk) disable iff (srst) // [R13]
    sfrRdEn && sfrAddr == xb_pkg::ADDR_LATCH && sfrRmw |=> sfrRdData == $past(latch_r))
    else $error("rmw did not read latch");
  chk_xbar_off: assert property (@(posedge ref_clk) disable iff (srst) // [R23]
    !xbarOn |=> padOe == 8'h00) else $error("driver on while crossbar off");
  chk_analog_quiet: assert property (@(posedge ref_clk) disable iff (srst) // [R15]
    ##1 ((padOe | padPullup) & ~$past(inKind_r)) == 8'h00) else $error("analog pin active");
  chk_weak_off: assert property (@(posedge ref_clk) disable iff (srst) // [R6]
    weakOff |=> padPullup == 8'h00) else $error("pullup on while disabled");
  chk_pull_low: assert property (@(posedge ref_clk) disable iff (srst) // [R24]
    (padPullup & padOe & ~padOut) == 8'h00) else $error("pullup on low drive");
  chk_two_wire_od: assert property (@(posedge ref_clk) disable iff (srst) // [R17]
    sdaOnQ |-> !(padOe[sdaPinQ] && padOut[sdaPinQ])) else $error("two-wire pin driven high");
  chk_skip_kept: assert property (@(posedge ref_clk) disable iff (srst) // [R18]
    (pinPeriph & skip_r) == 8'h00) else $error("skipped pin assigned");
  chk_match_evt: assert property (@(posedge ref_clk) disable iff (srst) // [R19]
    ##1 matchEvent == $past((padLevel_r & inKind_r & cmpMask_r) != (cmpVal_r & cmpMask_r)))
    else $error("match event wrong");
  chk_mask_zero: assert property (@(posedge ref_clk) disable iff (srst) // [R20]
    cmpMask_r == 8'h00 |=> !matchEvent) else $error("event with empty mask");
  chk_match_irq: assert property (@(posedge ref_clk) disable iff (srst) // [R21]
    matchIrq |-> matchEvent && wakeReq && $past(matchInterruptEnable)) else $error("irq without cause");
  chk_sync_hold: assert property (@(posedge ref_clk) disable iff (srst) // [R26]
    $past(padS2_r != padS3_r) |-> ((padLevel_r ^ $past(padLevel_r)) & $past(padS2_r ^ padS3_r)) == 8'h00)
    else $error("level changed before stages agree");

  // Routing, drive and register checks
  chk_cmp_gate: assert property ( // [R1]
    !xSel1_r[xb_pkg::X1_CMP0] |-> !sigOn[xb_pkg::SIG_CP0])
    else $error("comparator routed while off");
  chk_clk_toggle: assert property ( // [R2]
    !$past(srst) && $past(clockOutDivider) == 2'h0 |-> clkOut_r != $past(clkOut_r))
    else $error("clock out did not toggle");
  chk_two_wire_gate: assert property ( // [R3]
    !xSel1_r[xb_pkg::X1_TWO_WIRE] |-> !sigOn[xb_pkg::SIG_SDA] && !sigOn[xb_pkg::SIG_SCL])
    else $error("two-wire routed while off");
  chk_spi_select: assert property ( // [R4]
    !spiFourWire |-> !sigOn[xb_pkg::SIG_NSS])
    else $error("select routed in three-wire");
  chk_uart_rx_idle: assert property ( // [R5]
    uartOn |=> !padOe[rxPin])
    else $error("receive pin driven");
  chk_uart_rx_in: assert property ( // [R5]
    uartOn |=> periphIn.uartRx == $past(pinRead[rxPin]))
    else $error("receive level wrong");
  chk_pull_on: assert property ( // [R6]
    !weakOff |=> (~padPullup & ~padOe & $past(inKind_r)) == 8'h00)
    else $error("pullup missing");
  chk_route_off: assert property ( // [R7]
    !xbarOn |-> sigOn == '0 && pinPeriph == 8'h00 && uartMask == 8'h00)
    else $error("routing while crossbar off");
  chk_t0_idle: assert property ( // [R8]
    !sigOn[xb_pkg::SIG_T0] |=> periphIn.t0)
    else $error("unrouted timer input low");
  chk_eci_undriven: assert property ( // [R8]
    sigOn[xb_pkg::SIG_ECI] |=> !padOe[$past(sigPin[xb_pkg::SIG_ECI])])
    else $error("count input pin driven");
  chk_cex_reserved: assert property ( // [R9]
    cexCount == xb_pkg::CEX_RESERVED |-> cexEn == 6'h00)
    else $error("reserved module count routes");
  chk_cex_count: assert property ( // [R9]
    xbarOn && cexCount != xb_pkg::CEX_RESERVED |-> sigEn[xb_pkg::SIG_COUNTER_ARRAY_MODULE_SIGNAL +: 6] == 6'((7'h01 << cexCount) - 7'h01))
    else $error("module count wrong");
  chk_gpio_drive: assert property ( // [R10]
    xbarOn && !pinPeriph[0] && inKind_r[0] && mdOut_r[0] |=> padOe[0] && padOut[0] == $past(latch_r[0]))
    else $error("latch not on pin");
  chk_od_no_high: assert property ( // [R14]
    ##1 (padOe & padOut & ~$past(mdOut_r)) == 8'h00)
    else $error("open drain driven high");
  chk_inkind_write: assert property ( // [R15]
    wrInKind |=> inKind_r == $past(sfrWrData))
    else $error("input kind not loaded");
  chk_mode_write: assert property ( // [R16]
    wrMdOut |=> mdOut_r == $past(sfrWrData))
    else $error("output mode not loaded");
  chk_scl_od: assert property ( // [R17]
    sigOn[xb_pkg::SIG_SCL] |=> !(padOe[$past(sigPin[xb_pkg::SIG_SCL])] && padOut[$past(sigPin[xb_pkg::SIG_SCL])]))
    else $error("two-wire clock driven high");
  chk_skip_write: assert property ( // [R18]
    wrSkip |=> skip_r == $past(sfrWrData))
    else $error("bypass not loaded");
  chk_irq_off: assert property ( // [R21]
    !matchInterruptEnable |=> !matchIrq)
    else $error("irq while disabled");
  chk_wake_evt: assert property ( // [R21]
    wakeReq == matchEvent)
    else $error("wake differs from event");
  chk_first_free: assert property ( // [R22]
    sigOn[xb_pkg::SIG_SDA] && skip_r == 8'h00 && !uartOn |-> sigPin[xb_pkg::SIG_SDA] == 3'h0)
    else $error("first signal not on lowest pin");
  chk_xsel_write: assert property ( // [R25]
    wrXSel1 |=> xSel1_r == $past(sfrWrData))
    else $error("select not loaded");
  chk_level_take: assert property ( // [R26]
    ##1 ((padLevel_r ^ $past(padS2_r)) & $past(syncAgree)) == 8'h00)
    else $error("agreed level not taken");
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking testbench of the port zero block with its board model
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] sfrAddr = 8'h00;
  logic sfrWrEn = 1'b0;
  logic [7:0] sfrWrData = 8'h00;
  logic sfrRdEn = 1'b0;
  logic sfrRmw = 1'b0;
  logic [1:0] clockOutDivider = 2'h0;
  logic spiFourWire = 1'b0;
  logic matchInterruptEnable = 1'b0;
  xb_pkg::xb_periph_out_t periphOut = '0;
  xb_pkg::xb_periph_in_t periphIn;
  logic [7:0] extVal = 8'h00;
  logic [7:0] extEn = 8'h00;
  logic [7:0] sfrRdData, padLevel, padOut, padOe, padPullup, v, lat, md;
  logic matchEvent, matchIrq, wakeReq;
  logic rdSeen = 1'b0;
  logic [15:0] rng = 16'h381f;
  int bad_count = 0;
  int check_count = 0;
  int cnt;
  logic [7:0] expQ[$];
  string nameQ[$];
  // Index: latch, out mode, bypass, select one, select two, input kind, compare value, mask, unmapped
  logic [7:0] addrTab [9] = '{xb_pkg::ADDR_LATCH, xb_pkg::ADDR_MDOUT, xb_pkg::ADDR_SKIP, xb_pkg::ADDR_XSEL1,
    xb_pkg::ADDR_XSEL2, xb_pkg::ADDR_INKIND, xb_pkg::ADDR_CMPVAL, xb_pkg::ADDR_CMPMASK, 8'h00};
  logic [7:0] rstTab [9] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};

  always #12.5 ref_clk = ~ref_clk;

  xb_port_zero #(.PIN_COUNT(8), .LARGE_PACKAGE(1'b1)) i_dut (
    .ref_clk(ref_clk), .srst(srst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
    .sfrRdEn(sfrRdEn), .sfrRmw(sfrRmw), .sfrRdData(sfrRdData), .clockOutDivider(clockOutDivider),
    .spiFourWire(spiFourWire), .matchInterruptEnable(matchInterruptEnable), .periphOut(periphOut),
    .periphIn(periphIn), .padIn(padLevel), .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
    .matchEvent(matchEvent), .matchIrq(matchIrq), .wakeReq(wakeReq)
  );

  xb_board_model i_board (
    .ref_clk(ref_clk), .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
    .extVal(extVal), .extEn(extEn), .padLevel(padLevel)
  );

  function automatic logic [7:0] rand8();
    rng ^= rng << 7;
    rng ^= rng >> 9;
    rng ^= rng << 8;
    return rng[7:0];
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic wr(input int k, input logic [7:0] d);
    sfrAddr = addrTab[k];
    sfrWrData = d;
    sfrWrEn = 1'b1;
    @(negedge ref_clk);
    sfrWrEn = 1'b0;
    @(negedge ref_clk);
  endtask

  // Notes the expected read data; the monitor below compares it when the answer lands
  task automatic rd(input int k, input logic rmw, input logic [7:0] e, input string what);
    sfrAddr = addrTab[k];
    sfrRmw = rmw;
    sfrRdEn = 1'b1;
    expQ.push_back(e);
    nameQ.push_back(what);
    @(negedge ref_clk);
    sfrRdEn = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic do_reset();
    srst = 1'b1;
    cyc(6);
    srst = 1'b0;
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge ref_clk) rdSeen <= sfrRdEn & ~srst;

  always @(negedge ref_clk) begin
    if (rdSeen) begin
      if (expQ.size() == 0) begin
        expQ.push_back(8'hxx);
        nameQ.push_back("unexpected read");
      end
      chk(sfrRdData, expQ.pop_front(), nameQ.pop_front());
    end
  end

  initial begin
    cyc(20000);
    chk(8'h00, 8'h01, "run time limit");
    print_verdict();
  end

  initial begin
    do_reset();
    cyc(2);
    chk(padOe, 8'h00, "drive after reset");
    chk(padPullup, 8'hff, "pullup after reset");
    for (int i = 0; i < 9; i++) rd(i, 1'b1, rstTab[i], "reset value");
    for (int i = 0; i < 8; i++) begin
      v = rand8();
      wr(i, v);
      rd(i, 1'b1, v, "register readback");
    end
    wr(8, 8'h5a);
    rd(8, 1'b0, 8'h00, "unmapped read");
    do_reset();
    // General-purpose pins, open drain pulled low by the board where the latch is one
    lat = rand8();
    md = rand8();
    wr(1, md);
    wr(0, lat);
    wr(4, 8'h40);
    extEn = lat & ~md;
    cyc(6);
    rd(0, 1'b0, lat & md, "pin read");
    rd(0, 1'b1, lat, "latch read");
    chk(padPullup & ~md, lat & ~md, "open drain pullup");
    chk(padOe & md, md, "push pull drive");
    wr(4, 8'hc0);
    cyc(2);
    chk(padPullup & ~md, 8'h00, "pullups disabled");
    // Analog pins
    wr(1, 8'h00);
    wr(0, 8'hff);
    wr(4, 8'h40);
    wr(5, 8'hf0);
    v = rand8();
    extVal = v;
    extEn = 8'hff;
    cyc(6);
    rd(0, 1'b0, v & 8'hf0, "analog read");
    chk((padOe | padPullup) & 8'h0f, 8'h00, "analog pin idle");
    extEn = 8'h0f;
    wr(1, 8'hff);
    cyc(2);
    chk(padOe, 8'hf0, "analog ignores mode");
    wr(3, 8'hff);
    wr(4, 8'h00);
    extEn = 8'h00;
    wr(5, 8'hff);
    cyc(2);
    chk(padOe, 8'h00, "crossbar off");
    // Fixed UART pins, then two-wire lines placed around them
    extVal = 8'h00;
    extEn = 8'h04;
    wr(3, 8'h01);
    wr(4, 8'h40);
    cyc(6);
    chk(padOe, 8'hfb, "uart pins");
    chk(padOut & padOe, 8'hf9, "uart transmit");
    chk({7'h00, periphIn.uartRx}, 8'h00, "uart receive");
    periphOut.twoWireClk = 1'b1;
    wr(3, 8'h05);
    cyc(2);
    chk(padOe, 8'hf3, "two wire beside uart");
    chk(padOut & padOe, 8'hf0, "two wire data low");
    wr(3, 8'h04);
    wr(2, 8'h01);
    cyc(2);
    chk(padOe, 8'hfb, "two wire after bypass");
    chk(padOut & padOe, 8'hf9, "bypass pin stays gpio");
    chk({7'h00, periphIn.twoWireClk}, 8'h00, "two wire clock in");
    // SPI in three and four wire form
    wr(2, 8'h00);
    extEn = 8'h02;
    wr(3, 8'h02);
    cyc(2);
    chk(padOe, 8'hfd, "spi pins");
    chk(padOut & padOe, 8'hf8, "spi three wire");
    spiFourWire = 1'b1;
    cyc(3);
    chk(padOut & padOe, 8'hf0, "spi four wire");
    chk({7'h00, periphIn.spiMiso}, 8'h00, "spi miso in");
    // Comparator outputs, one route at a time
    spiFourWire = 1'b0;
    extEn = 8'h00;
    periphOut.cmp0 = 1'b1;
    periphOut.cmp0Async = 1'b1;
    periphOut.cmp1 = 1'b1;
    periphOut.cmp1Async = 1'b1;
    wr(0, 8'h00);
    for (int i = 4; i < 8; i++) begin
      wr(3, 8'h01 << i);
      cyc(2);
      chk(padOut, 8'h01, "comparator route");
    end
    // Divided clock out
    wr(3, 8'h08);
    for (int d = 0; d < 3; d += 2) begin
      clockOutDivider = 2'(d);
      cyc(20);
      cnt = 0;
      v[0] = padOut[0];
      repeat (64) begin
        @(negedge ref_clk);
        cnt += int'(padOut[0] != v[0]);
        v[0] = padOut[0];
      end
      chk(8'(cnt), 8'(64 >> d), "clock out toggles");
    end
    // Counter array module count, then count and timer inputs
    wr(3, 8'h00);
    periphOut.cex = 6'h3f;
    for (int n = 0; n < 8; n++) begin
      wr(4, 8'h40 | 8'(n));
      cyc(2);
      chk(padOut, (n == 7) ? 8'h00 : 8'((1 << n) - 1), "module pins");
    end
    extVal = 8'h05;
    extEn = 8'h07;
    wr(4, 8'h78);
    cyc(6);
    chk(padOe, 8'hf8, "count inputs undriven");
    chk({5'h00, periphIn.counter_array_external_count, periphIn.t0, periphIn.t1}, 8'h05, "count inputs");
    // Masked pin match
    wr(4, 8'h00);
    v = rand8();
    extVal = v;
    extEn = 8'hff;
    matchInterruptEnable = 1'b1;
    wr(7, 8'h0f);
    wr(6, {~v[7:4], v[3:0]});
    cyc(6);
    chk({5'h00, matchEvent, matchIrq, wakeReq}, 8'h00, "match equal");
    extVal = v ^ 8'h80;
    cyc(6);
    chk({5'h00, matchEvent, matchIrq, wakeReq}, 8'h00, "masked pin ignored");
    extVal = v ^ 8'h04;
    cyc(6);
    chk({5'h00, matchEvent, matchIrq, wakeReq}, 8'h07, "match differs");
    matchInterruptEnable = 1'b0;
    cyc(2);
    chk({5'h00, matchEvent, matchIrq, wakeReq}, 8'h05, "match irq disabled");
    cyc(4);
    print_verdict();
  end
endmodule
`default_nettype wire

// *** verif/xb_board_model.sv ***
// Board-side model of the port zero pins: device drive, board drivers and weak pullups
`timescale 1ns/1ps
`default_nettype none
module xb_board_model (
  input wire logic ref_clk,
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOe,
  input wire logic [7:0] padPullup,
  input wire logic [7:0] extVal,
  input wire logic [7:0] extEn,
  output logic [7:0] padLevel
);
  logic [7:0] floatPat = 8'h5a;
  // A pin that nobody drives and nothing pulls up wanders every cycle
  always @(posedge ref_clk) begin
    floatPat <= ~floatPat;
  end
  // Device drive first, then board drivers, then weak pullup or a floating level
  assign padLevel = (padOe & padOut) | (~padOe & extEn & extVal)
    | (~padOe & ~extEn & (padPullup | floatPat));
endmodule
`default_nettype wire
